// ### src/sbpl_pkg.sv
package sbpl_pkg;
  localparam logic [7:0] SBPL_ACK_BYTE     = 8'hcc;
  localparam logic [7:0] SBPL_NAK_BYTE     = 8'h33;
  localparam logic [6:0] SBPL_I2C_ADDR     = 7'h42;
  localparam int         SBPL_BAUD_W       = 24;
  localparam logic [3:0] SBPL_AB_SPAN_FALLS = 4'h8;
  localparam logic [3:0] SBPL_AB_LAST_FALLS = 4'h9;
  localparam int         SBPL_AB_SHIFT     = 4;
  localparam logic [3:0] SBPL_DATA_BITS    = 4'h8;
  localparam logic [3:0] SBPL_FRAME_BITS   = 4'ha;
  localparam logic [7:0] SBPL_MIN_LEN      = 8'h02;
  localparam int         SBPL_PIN_RX       = 0;
  localparam int         SBPL_PIN_SCK      = 1;
  localparam int         SBPL_PIN_CSN      = 2;
  localparam int         SBPL_PIN_MOSI     = 3;
  localparam int         SBPL_PIN_SCL      = 4;
  localparam int         SBPL_PIN_SDA      = 5;
  localparam int         SBPL_PINS         = 6;

  typedef enum logic [1:0] {
    SBPL_PORT_NONE     = 2'b00,
    SBPL_PORT_ASYNC    = 2'b01,
    SBPL_PORT_SYNC     = 2'b10,
    SBPL_PORT_TWO_WIRE = 2'b11
  } sbpl_port_t;
endpackage : sbpl_pkg

// ### src/sbpl_byte_if.sv
`timescale 1ns/10ps
`default_nettype none
interface sbpl_byte_if;
  logic       rx_valid;
  logic [7:0] rx_data;
  logic       tx_valid;
  logic [7:0] tx_data;
  logic       tx_take;
  logic       locked;
  modport port (output rx_valid, output rx_data, output tx_take, output locked,
                input tx_valid, input tx_data);
  modport core (input rx_valid, input rx_data, input tx_take, input locked,
                output tx_valid, output tx_data);
endinterface : sbpl_byte_if
`default_nettype wire

// ### src/sbpl_uart.sv
`timescale 1ns/10ps
`default_nettype none
module sbpl_uart
  import sbpl_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic rx_in,
  input  wire logic en_in,
  output var  logic tx_out,
  sbpl_byte_if.port bus
);
  typedef enum logic [2:0] {
    SBPL_AB_IDLE = 3'b000,
    SBPL_AB_MEAS = 3'b001,
    SBPL_AB_TAIL = 3'b010,
    SBPL_AB_CONF = 3'b011,
    SBPL_RUN     = 3'b100
  } sbpl_ab_t;

  sbpl_ab_t               st_q, st_d;
  logic [SBPL_BAUD_W-1:0] cnt_q, cnt_d, bit_q, bit_d, rcnt_q, rcnt_d, tcnt_q, tcnt_d;
  logic [3:0]             falls_q, falls_d, rbit_q, rbit_d, tbit_q, tbit_d;
  logic [7:0]             rsh_q, rsh_d;
  logic [9:0]             tsh_q, tsh_d;
  logic                   prev_q, rxb_q, rxb_d, tbusy_q, tbusy_d, conf_q, conf_d;
  logic                   tx_q, tx_d, rv_q, rv_d, take_d, take_q;
  logic                   fall;

  assign fall         = prev_q & ~rx_in;
  assign bus.rx_valid = rv_q;
  assign bus.rx_data  = rsh_q;
  assign bus.tx_take  = take_q;
  assign bus.locked   = (st_q == SBPL_RUN);
  assign tx_out       = tx_q;

  always_comb begin
    st_d = st_q; cnt_d = cnt_q; bit_d = bit_q; falls_d = falls_q;
    rcnt_d = rcnt_q; rbit_d = rbit_q; rsh_d = rsh_q; rxb_d = rxb_q; rv_d = 1'b0;
    tcnt_d = tcnt_q; tbit_d = tbit_q; tsh_d = tsh_q; tbusy_d = tbusy_q;
    conf_d = conf_q; tx_d = tx_q; take_d = 1'b0;
    unique case (st_q)
      SBPL_AB_IDLE: if (en_in && fall) begin
        st_d = SBPL_AB_MEAS; cnt_d = '0; falls_d = '0;
      end
      SBPL_AB_MEAS: begin
        cnt_d = cnt_q + 1'b1;
        if (&cnt_q || !en_in) st_d = SBPL_AB_IDLE;
        else if (fall) begin
          falls_d = falls_q + 1'b1;
          if (falls_q == SBPL_AB_SPAN_FALLS - 4'h1) begin
            bit_d = cnt_q >> SBPL_AB_SHIFT;
            st_d  = SBPL_AB_TAIL;
          end
        end
      end
      SBPL_AB_TAIL: if (fall) begin
        falls_d = falls_q + 1'b1;
        if (falls_q == SBPL_AB_LAST_FALLS - 4'h1) begin
          st_d = SBPL_AB_CONF; cnt_d = '0;
        end
      end
      SBPL_AB_CONF: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q >= {bit_q[SBPL_BAUD_W-2:0], 1'b0}) begin
          st_d = SBPL_RUN; conf_d = 1'b1;
        end
      end
      SBPL_RUN: begin
        if (!rxb_q) begin
          if (fall) begin rxb_d = 1'b1; rcnt_d = '0; rbit_d = '0; end
        end else if ((rbit_q == 4'h0) ? (rcnt_q >= (bit_q >> 1)) : (rcnt_q >= bit_q)) begin
          rcnt_d = '0;
          rbit_d = rbit_q + 1'b1;
          if (rbit_q == 4'h0 && rx_in) rxb_d = 1'b0;
          else if (rbit_q == SBPL_DATA_BITS + 4'h1) begin
            rxb_d = 1'b0;
            rv_d  = rx_in;
          end else if (rbit_q != 4'h0) rsh_d = {rx_in, rsh_q[7:1]};
        end else rcnt_d = rcnt_q + 1'b1;
      end
      default: st_d = SBPL_AB_IDLE;
    endcase
    if (!tbusy_q) begin
      if (conf_q) begin
        tsh_d = {1'b1, SBPL_ACK_BYTE, 1'b0}; tbusy_d = 1'b1; conf_d = 1'b0;
        tcnt_d = '0; tbit_d = '0;
      end else if (st_q == SBPL_RUN && bus.tx_valid) begin
        tsh_d = {1'b1, bus.tx_data, 1'b0}; tbusy_d = 1'b1; take_d = 1'b1;
        tcnt_d = '0; tbit_d = '0;
      end
    end else if (tcnt_q == '0) begin
      tx_d = tsh_q[0];
      tsh_d = {1'b1, tsh_q[9:1]};
      tcnt_d = tcnt_q + 1'b1;
      if (tbit_q == SBPL_FRAME_BITS) tbusy_d = 1'b0;
    end else if (tcnt_q >= bit_q) begin
      tcnt_d = '0; tbit_d = tbit_q + 1'b1;
    end else tcnt_d = tcnt_q + 1'b1;
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_q <= SBPL_AB_IDLE; cnt_q <= '0; bit_q <= '0; falls_q <= '0;
      rcnt_q <= '0; rbit_q <= '0; rsh_q <= '0; rxb_q <= 1'b0; rv_q <= 1'b0;
      tcnt_q <= '0; tbit_q <= '0; tsh_q <= '1; tbusy_q <= 1'b0;
      conf_q <= 1'b0; tx_q <= 1'b1; take_q <= 1'b0; prev_q <= 1'b1;
    end else begin
      st_q <= st_d; cnt_q <= cnt_d; bit_q <= bit_d; falls_q <= falls_d;
      rcnt_q <= rcnt_d; rbit_q <= rbit_d; rsh_q <= rsh_d; rxb_q <= rxb_d; rv_q <= rv_d;
      tcnt_q <= tcnt_d; tbit_q <= tbit_d; tsh_q <= tsh_d; tbusy_q <= tbusy_d;
      conf_q <= conf_d; tx_q <= tx_d; take_q <= take_d; prev_q <= rx_in;
    end
  end
endmodule : sbpl_uart
`default_nettype wire

// ### src/sbpl_top.sv
`timescale 1ns/10ps
`default_nettype none
module sbpl_top
  import sbpl_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  input  wire logic       uart_rx_in,
  output var  logic       uart_tx_out,
  input  wire logic       spi_sck_in,
  input  wire logic       spi_cs_n_in,
  input  wire logic       spi_mosi_in,
  output var  logic       spi_miso_out,
  input  wire logic       i2c_scl_in,
  input  wire logic       i2c_sda_in,
  output var  logic       i2c_sda_out,
  output var  logic       i2c_sda_oe_n_out,
  input  wire logic       tx_start_in,
  input  wire logic [7:0] tx_len_in,
  input  wire logic [7:0] tx_byte_in,
  output var  logic [7:0] tx_index_out,
  output var  logic       tx_busy_out,
  output var  logic       tx_acked_out,
  output var  logic       tx_nacked_out,
  output var  logic [7:0] rx_byte_out,
  output var  logic       rx_byte_valid_out,
  output var  logic       rx_done_out,
  output var  logic       rx_good_out,
  output var  logic [1:0] active_port_out
);
  typedef enum logic [2:0] {
    SBPL_I2C_IDLE = 3'b000,
    SBPL_I2C_ADDR = 3'b001,
    SBPL_I2C_AACK = 3'b010,
    SBPL_I2C_WR   = 3'b011,
    SBPL_I2C_WACK = 3'b100,
    SBPL_I2C_RD   = 3'b101,
    SBPL_I2C_RACK = 3'b110
  } sbpl_i2c_t;
  typedef enum logic [1:0] {
    SBPL_R_LEN  = 2'b00,
    SBPL_R_SUM  = 2'b01,
    SBPL_R_DATA = 2'b10
  } sbpl_rx_t;
  typedef enum logic [2:0] {
    SBPL_T_IDLE = 3'b000,
    SBPL_T_SUM  = 3'b001,
    SBPL_T_LEN  = 3'b010,
    SBPL_T_CHK  = 3'b011,
    SBPL_T_DATA = 3'b100,
    SBPL_T_ACK  = 3'b101
  } sbpl_tx_t;

  function automatic logic [7:0] sbpl_pick(input logic v, input logic [7:0] d);
    sbpl_pick = v ? d : 8'h00;
  endfunction : sbpl_pick

  // pin synchronisers
  logic [SBPL_PINS-1:0] s1_q, s2_q, s3_q;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s1_q <= '1; s2_q <= '1; s3_q <= '1;
    end else begin
      s1_q <= {i2c_sda_in, i2c_scl_in, spi_mosi_in, spi_cs_n_in, spi_sck_in, uart_rx_in};
      s2_q <= s1_q; s3_q <= s2_q;
    end
  end
  logic sck_rise, sck_fall, scl_rise, scl_fall, i2c_start, i2c_stop, cs_act;
  assign sck_rise  = s2_q[SBPL_PIN_SCK] & ~s3_q[SBPL_PIN_SCK];
  assign sck_fall  = ~s2_q[SBPL_PIN_SCK] & s3_q[SBPL_PIN_SCK];
  assign scl_rise  = s2_q[SBPL_PIN_SCL] & ~s3_q[SBPL_PIN_SCL];
  assign scl_fall  = ~s2_q[SBPL_PIN_SCL] & s3_q[SBPL_PIN_SCL];
  assign i2c_start = s2_q[SBPL_PIN_SCL] & s3_q[SBPL_PIN_SCL]
                     & ~s2_q[SBPL_PIN_SDA] & s3_q[SBPL_PIN_SDA];
  assign i2c_stop  = s2_q[SBPL_PIN_SCL] & s3_q[SBPL_PIN_SCL]
                     & s2_q[SBPL_PIN_SDA] & ~s3_q[SBPL_PIN_SDA];
  assign cs_act    = ~s2_q[SBPL_PIN_CSN];

  // port selection and shared byte queue
  sbpl_port_t sel_q, sel_d;
  logic       txq_v_q, txq_v_d;
  logic [7:0] txq_d_q, txq_d_d;
  logic       spi_rv, i2c_rv, i2c_hit, spi_take, i2c_take, rx_v, tx_take;
  logic [7:0] spi_rd, i2c_rd, rx_d;
  sbpl_byte_if ubus ();
  assign ubus.tx_valid = txq_v_q & (sel_q == SBPL_PORT_ASYNC);
  assign ubus.tx_data  = txq_d_q;

  sbpl_uart u_uart (
    .clk_in  (clk_in),
    .nrst_in (nrst_in),
    .rx_in   (s2_q[SBPL_PIN_RX]),
    .en_in   (sel_q == SBPL_PORT_NONE || sel_q == SBPL_PORT_ASYNC),
    .tx_out  (uart_tx_out),
    .bus     (ubus)
  );

  always_comb begin
    sel_d = sel_q;
    if (sel_q == SBPL_PORT_NONE) begin
      if (ubus.locked) sel_d = SBPL_PORT_ASYNC;
      else if (spi_rv) sel_d = SBPL_PORT_SYNC;
      else if (i2c_hit) sel_d = SBPL_PORT_TWO_WIRE;
    end
    unique case (sel_q)
      SBPL_PORT_ASYNC:    begin rx_v = ubus.rx_valid; rx_d = ubus.rx_data; tx_take = ubus.tx_take; end
      SBPL_PORT_SYNC:     begin rx_v = spi_rv; rx_d = spi_rd; tx_take = spi_take; end
      SBPL_PORT_TWO_WIRE: begin rx_v = i2c_rv; rx_d = i2c_rd; tx_take = i2c_take; end
      default:            begin rx_v = 1'b0; rx_d = 8'h00; tx_take = 1'b0; end
    endcase
  end

  // sync serial slave, idle-high clock, drive on fall, sample on rise
  logic [3:0] sp_cnt_q, sp_cnt_d;
  logic [7:0] sp_rsh_q, sp_rsh_d, sp_tsh_q, sp_tsh_d;
  logic       sp_miso_q, sp_miso_d, sp_rv_q, sp_rv_d, sp_take_q, sp_take_d;
  logic       sp_en;
  assign sp_en  = (sel_q == SBPL_PORT_NONE || sel_q == SBPL_PORT_SYNC) && cs_act;
  assign spi_rv = sp_rv_q;
  assign spi_rd = sp_rsh_q;
  assign spi_take = sp_take_q;
  always_comb begin
    sp_cnt_d = sp_cnt_q; sp_rsh_d = sp_rsh_q; sp_tsh_d = sp_tsh_q;
    sp_miso_d = sp_miso_q; sp_rv_d = 1'b0; sp_take_d = 1'b0;
    if (!sp_en) begin
      sp_cnt_d = '0; sp_miso_d = 1'b1;
    end else if (sck_fall) begin
      if (sp_cnt_q == 4'h0) begin
        sp_tsh_d  = {sbpl_pick(txq_v_q, txq_d_q)} << 1;
        sp_miso_d = sbpl_pick(txq_v_q, txq_d_q) >> 7 != 8'h00;
        sp_take_d = txq_v_q && (sel_q == SBPL_PORT_SYNC);
      end else begin
        sp_miso_d = sp_tsh_q[7];
        sp_tsh_d  = {sp_tsh_q[6:0], 1'b0};
      end
    end else if (sck_rise) begin
      sp_rsh_d = {sp_rsh_q[6:0], s2_q[SBPL_PIN_MOSI]};
      if (sp_cnt_q == SBPL_DATA_BITS - 4'h1) begin
        sp_cnt_d = '0;
        sp_rv_d  = 1'b1;
      end else sp_cnt_d = sp_cnt_q + 1'b1;
    end
  end
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sp_cnt_q <= '0; sp_rsh_q <= '0; sp_tsh_q <= '0;
      sp_miso_q <= 1'b1; sp_rv_q <= 1'b0; sp_take_q <= 1'b0;
    end else begin
      sp_cnt_q <= sp_cnt_d; sp_rsh_q <= sp_rsh_d; sp_tsh_q <= sp_tsh_d;
      sp_miso_q <= sp_miso_d; sp_rv_q <= sp_rv_d; sp_take_q <= sp_take_d;
    end
  end
  assign spi_miso_out = sp_miso_q;

  // two-wire slave, edge driven so standard and fast rates both work
  sbpl_i2c_t  ic_st_q, ic_st_d;
  logic [3:0] ic_cnt_q, ic_cnt_d;
  logic [7:0] ic_sh_q, ic_sh_d;
  logic       ic_low_q, ic_low_d, ic_rw_q, ic_rw_d, ic_rv_q, ic_rv_d;
  logic       ic_take_q, ic_take_d, ic_hit_q, ic_hit_d, ic_en;
  assign ic_en    = (sel_q == SBPL_PORT_NONE || sel_q == SBPL_PORT_TWO_WIRE);
  assign i2c_rv   = ic_rv_q;
  assign i2c_rd   = ic_sh_q;
  assign i2c_take = ic_take_q;
  assign i2c_hit  = ic_hit_q;
  always_comb begin
    ic_st_d = ic_st_q; ic_cnt_d = ic_cnt_q; ic_sh_d = ic_sh_q; ic_low_d = ic_low_q;
    ic_rw_d = ic_rw_q; ic_rv_d = 1'b0; ic_take_d = 1'b0; ic_hit_d = 1'b0;
    if (!ic_en || i2c_stop) begin
      ic_st_d = SBPL_I2C_IDLE; ic_low_d = 1'b0;
    end else if (i2c_start) begin
      ic_st_d = SBPL_I2C_ADDR; ic_cnt_d = '0; ic_low_d = 1'b0;
    end else if (scl_rise) begin
      if (ic_st_q == SBPL_I2C_ADDR || ic_st_q == SBPL_I2C_WR) begin
        ic_sh_d  = {ic_sh_q[6:0], s2_q[SBPL_PIN_SDA]};
        ic_cnt_d = ic_cnt_q + 1'b1;
      end else if (ic_st_q == SBPL_I2C_RD) ic_cnt_d = ic_cnt_q + 1'b1;
      else if (ic_st_q == SBPL_I2C_RACK && s2_q[SBPL_PIN_SDA]) ic_st_d = SBPL_I2C_IDLE;
    end else if (scl_fall) begin
      unique case (ic_st_q)
        SBPL_I2C_ADDR: if (ic_cnt_q == SBPL_DATA_BITS) begin
          if (ic_sh_q[7:1] == SBPL_I2C_ADDR) begin
            ic_low_d = 1'b1; ic_rw_d = ic_sh_q[0]; ic_hit_d = 1'b1;
            ic_st_d = SBPL_I2C_AACK;
          end else ic_st_d = SBPL_I2C_IDLE;
        end
        SBPL_I2C_WR: if (ic_cnt_q == SBPL_DATA_BITS) begin
          ic_low_d = 1'b1; ic_rv_d = 1'b1; ic_st_d = SBPL_I2C_WACK;
        end
        SBPL_I2C_AACK, SBPL_I2C_RACK: begin
          ic_cnt_d = '0;
          if (ic_rw_q) begin
            ic_sh_d   = sbpl_pick(txq_v_q, txq_d_q);
            ic_low_d  = ~sbpl_pick(txq_v_q, txq_d_q) >> 7 != 8'h00;
            ic_take_d = txq_v_q && (sel_q == SBPL_PORT_TWO_WIRE);
            ic_st_d   = SBPL_I2C_RD;
          end else begin
            ic_low_d = 1'b0; ic_st_d = SBPL_I2C_WR;
          end
        end
        SBPL_I2C_WACK: begin
          ic_low_d = 1'b0; ic_cnt_d = '0; ic_st_d = SBPL_I2C_WR;
        end
        SBPL_I2C_RD: if (ic_cnt_q == SBPL_DATA_BITS) begin
          ic_low_d = 1'b0; ic_st_d = SBPL_I2C_RACK;
        end else begin
          ic_sh_d  = {ic_sh_q[6:0], 1'b0};
          ic_low_d = ~ic_sh_q[6];
        end
        default: ic_low_d = 1'b0;
      endcase
    end
  end
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ic_st_q <= SBPL_I2C_IDLE; ic_cnt_q <= '0; ic_sh_q <= '0; ic_low_q <= 1'b0;
      ic_rw_q <= 1'b0; ic_rv_q <= 1'b0; ic_take_q <= 1'b0; ic_hit_q <= 1'b0;
    end else begin
      ic_st_q <= ic_st_d; ic_cnt_q <= ic_cnt_d; ic_sh_q <= ic_sh_d; ic_low_q <= ic_low_d;
      ic_rw_q <= ic_rw_d; ic_rv_q <= ic_rv_d; ic_take_q <= ic_take_d; ic_hit_q <= ic_hit_d;
    end
  end
  assign i2c_sda_out      = 1'b0;
  assign i2c_sda_oe_n_out = ~ic_low_q;

  // packet framer, common to all ports
  sbpl_rx_t   r_st_q, r_st_d;
  sbpl_tx_t   t_st_q, t_st_d;
  logic [7:0] r_cnt_q, r_cnt_d, r_sum_q, r_sum_d, r_exp_q, r_exp_d, r_fin;
  logic [7:0] t_idx_q, t_idx_d, t_sum_q, t_sum_d, t_len_q, t_len_d;
  logic       rep_v_q, rep_v_d, fin;
  logic [7:0] rep_d_q, rep_d_d, ob_q, ob_d;
  logic       obv_q, obv_d, dn_q, dn_d, gd_q, gd_d, ak_q, ak_d, nk_q, nk_d;
  always_comb begin
    r_st_d = r_st_q; r_cnt_d = r_cnt_q; r_sum_d = r_sum_q; r_exp_d = r_exp_q;
    t_st_d = t_st_q; t_idx_d = t_idx_q; t_sum_d = t_sum_q; t_len_d = t_len_q;
    rep_v_d = rep_v_q; rep_d_d = rep_d_q; ob_d = ob_q; obv_d = 1'b0;
    dn_d = 1'b0; gd_d = gd_q; ak_d = 1'b0; nk_d = 1'b0; fin = 1'b0; r_fin = r_sum_q;
    txq_v_d = txq_v_q & ~tx_take; txq_d_d = txq_d_q;
    if (rx_v) begin
      if (t_st_q == SBPL_T_ACK) begin
        if (rx_d != 8'h00) begin
          ak_d = (rx_d == SBPL_ACK_BYTE); nk_d = (rx_d != SBPL_ACK_BYTE);
          t_st_d = SBPL_T_IDLE;
        end
      end else begin
        unique case (r_st_q)
          SBPL_R_LEN: if (rx_d == 8'h01) begin
            rep_v_d = 1'b1; rep_d_d = SBPL_NAK_BYTE; dn_d = 1'b1; gd_d = 1'b0;
          end else if (rx_d != 8'h00) begin
            r_cnt_d = rx_d - SBPL_MIN_LEN; r_st_d = SBPL_R_SUM;
          end
          SBPL_R_SUM: begin
            r_exp_d = rx_d; r_sum_d = 8'h00; r_fin = 8'h00;
            if (r_cnt_q == 8'h00) fin = 1'b1;
            else r_st_d = SBPL_R_DATA;
          end
          default: begin
            r_fin = r_sum_q + rx_d;
            r_sum_d = r_fin; r_cnt_d = r_cnt_q - 8'h01;
            ob_d = rx_d; obv_d = 1'b1;
            if (r_cnt_q == 8'h01) fin = 1'b1;
          end
        endcase
        if (fin) begin
          rep_v_d = 1'b1; dn_d = 1'b1; gd_d = (r_fin == r_exp_d);
          rep_d_d = (r_fin == r_exp_d) ? SBPL_ACK_BYTE : SBPL_NAK_BYTE;
          r_st_d = SBPL_R_LEN;
        end
      end
    end
    if (t_st_q == SBPL_T_IDLE && tx_start_in && tx_len_in >= SBPL_MIN_LEN) begin
      t_len_d = tx_len_in; t_idx_d = 8'h00; t_sum_d = 8'h00;
      t_st_d = (tx_len_in == SBPL_MIN_LEN) ? SBPL_T_LEN : SBPL_T_SUM;
    end else if (t_st_q == SBPL_T_SUM) begin
      t_sum_d = t_sum_q + tx_byte_in;
      t_idx_d = t_idx_q + 8'h01;
      if (t_idx_q == t_len_q - 8'h03) begin t_idx_d = 8'h00; t_st_d = SBPL_T_LEN; end
    end
    if (!txq_v_d) begin
      if (rep_v_q) begin
        txq_v_d = 1'b1; txq_d_d = rep_d_q; rep_v_d = 1'b0;
      end else if (t_st_q == SBPL_T_LEN) begin
        txq_v_d = 1'b1; txq_d_d = t_len_q; t_st_d = SBPL_T_CHK;
      end else if (t_st_q == SBPL_T_CHK) begin
        txq_v_d = 1'b1; txq_d_d = t_sum_q;
        t_st_d = (t_len_q == SBPL_MIN_LEN) ? SBPL_T_ACK : SBPL_T_DATA;
      end else if (t_st_q == SBPL_T_DATA) begin
        txq_v_d = 1'b1; txq_d_d = tx_byte_in; t_idx_d = t_idx_q + 8'h01;
        if (t_idx_q == t_len_q - 8'h03) t_st_d = SBPL_T_ACK;
      end
    end
  end
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sel_q <= SBPL_PORT_NONE; txq_v_q <= 1'b0; txq_d_q <= '0;
      r_st_q <= SBPL_R_LEN; r_cnt_q <= '0; r_sum_q <= '0; r_exp_q <= '0;
      t_st_q <= SBPL_T_IDLE; t_idx_q <= '0; t_sum_q <= '0; t_len_q <= '0;
      rep_v_q <= 1'b0; rep_d_q <= '0; ob_q <= '0; obv_q <= 1'b0;
      dn_q <= 1'b0; gd_q <= 1'b0; ak_q <= 1'b0; nk_q <= 1'b0;
    end else begin
      sel_q <= sel_d; txq_v_q <= txq_v_d; txq_d_q <= txq_d_d;
      r_st_q <= r_st_d; r_cnt_q <= r_cnt_d; r_sum_q <= r_sum_d; r_exp_q <= r_exp_d;
      t_st_q <= t_st_d; t_idx_q <= t_idx_d; t_sum_q <= t_sum_d; t_len_q <= t_len_d;
      rep_v_q <= rep_v_d; rep_d_q <= rep_d_d; ob_q <= ob_d; obv_q <= obv_d;
      dn_q <= dn_d; gd_q <= gd_d; ak_q <= ak_d; nk_q <= nk_d;
    end
  end
  assign tx_index_out      = t_idx_q;
  assign tx_busy_out       = (t_st_q != SBPL_T_IDLE);
  assign tx_acked_out      = ak_q;
  assign tx_nacked_out     = nk_q;
  assign rx_byte_out       = ob_q;
  assign rx_byte_valid_out = obv_q;
  assign rx_done_out       = dn_q;
  assign rx_good_out       = gd_q;
  assign active_port_out   = sel_q;
endmodule : sbpl_top
`default_nettype wire

// ### test/sbpl_top_properties.sv
`timescale 1ns/10ps
`default_nettype none
module sbpl_top_properties
  import sbpl_pkg::*;
(
  input wire logic       clk_in,
  input wire logic       nrst_in,
  input wire logic       uart_tx_out,
  input wire logic       spi_cs_n_in,
  input wire logic       spi_miso_out,
  input wire logic       i2c_sda_oe_n_out,
  input wire logic       tx_start_in,
  input wire logic [7:0] tx_len_in,
  input wire logic       tx_busy_out,
  input wire logic       tx_acked_out,
  input wire logic       tx_nacked_out,
  input wire logic       rx_done_out,
  input wire logic [1:0] active_port_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  port_sticky_a: assert property (active_port_out != 2'h0 |=> $stable(active_port_out))
    else $error("claimed port changed");
  async_quiet_a: assert property (active_port_out[1] |-> uart_tx_out)
    else $error("async line moved on other port");
  sda_quiet_a: assert property (active_port_out != SBPL_PORT_TWO_WIRE |-> i2c_sda_oe_n_out)
    else $error("two-wire data pulled on other port");
  miso_idle_a: assert property (spi_cs_n_in [*6] |-> spi_miso_out)
    else $error("miso low while deselected");
  ack_excl_a: assert property (!(tx_acked_out && tx_nacked_out))
    else $error("ack and nack together");
  ack_busy_a: assert property ($rose(tx_acked_out | tx_nacked_out) |-> $past(tx_busy_out))
    else $error("answer seen while idle");
  short_len_a: assert property (tx_start_in && !tx_busy_out && tx_len_in < SBPL_MIN_LEN
    |=> !tx_busy_out) else $error("short length started");
  done_pulse_a: assert property (rx_done_out |=> !rx_done_out)
    else $error("done held");
  ack_seen_c: cover property (tx_acked_out);
  nak_seen_c: cover property (tx_nacked_out);
  rx_end_c: cover property (rx_done_out);
endmodule : sbpl_top_properties
bind sbpl_top sbpl_top_properties u_props (.clk_in, .nrst_in, .uart_tx_out, .spi_cs_n_in,
  .spi_miso_out, .i2c_sda_oe_n_out, .tx_start_in, .tx_len_in, .tx_busy_out, .tx_acked_out,
  .tx_nacked_out, .rx_done_out, .active_port_out);
`default_nettype wire

// ### test/sbpl_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module sbpl_host_model #(
  parameter int BIT_NS = 160
) (
  output var  logic       line_out,
  input  wire logic       line_in,
  output var  logic [7:0] got_out,
  output var  logic       got_valid_out
);
  initial begin
    line_out = 1'b1;
    got_valid_out = 1'b0;
  end
  task automatic send(input logic [7:0] b);
    line_out = 1'b0;
    #BIT_NS;
    for (int i = 0; i < 8; i++) begin
      line_out = b[i];
      #BIT_NS;
    end
    line_out = 1'b1;
    #BIT_NS;
  endtask : send
  always begin
    @(negedge line_in);
    #(BIT_NS * 3 / 2);
    for (int i = 0; i < 8; i++) begin
      got_out[i] = line_in;
      #BIT_NS;
    end
    got_valid_out = 1'b1;
    #(BIT_NS / 2);
    got_valid_out = 1'b0;
  end
endmodule : sbpl_host_model
`default_nettype wire

// ### test/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import sbpl_pkg::*;
  logic       clk_in = 1'b0, nrst_in = 1'b0, tx_start_in = 1'b0, i2c_scl_in = 1'b1;
  logic       spi_sck_in = 1'b1, spi_cs_n_in = 1'b1, spi_mosi_in = 1'b0;
  logic       uart_rx_in, uart_tx_out, spi_miso_out, i2c_sda_in, i2c_sda_out, i2c_sda_oe_n_out;
  logic       tx_busy_out, tx_acked_out, tx_nacked_out, rx_byte_valid_out, rx_done_out;
  logic       rx_good_out, gv;
  logic [7:0] tx_len_in = 8'h00, got, tx_index_out, rx_byte_out, tx_byte_in;
  logic [1:0] active_port_out;
  logic [7:0] pay [4] = '{default: 8'h00};
  logic [7:0] eq [$], pq [$];
  logic       gq [$], aq [$];
  int         failures = 0, check_count = 0;
  always #2 clk_in = ~clk_in;
  assign i2c_sda_in = i2c_sda_oe_n_out ? 1'b1 : i2c_sda_out;
  assign tx_byte_in = pay[tx_index_out[1:0]];
  sbpl_top u_dut (.clk_in, .nrst_in, .uart_rx_in, .uart_tx_out, .spi_sck_in, .spi_cs_n_in,
    .spi_mosi_in, .spi_miso_out, .i2c_scl_in, .i2c_sda_in, .i2c_sda_out, .i2c_sda_oe_n_out,
    .tx_start_in, .tx_len_in, .tx_byte_in, .tx_index_out, .tx_busy_out, .tx_acked_out,
    .tx_nacked_out, .rx_byte_out, .rx_byte_valid_out, .rx_done_out, .rx_good_out,
    .active_port_out);
  sbpl_host_model u_host (.line_out(uart_rx_in), .line_in(uart_tx_out), .got_out(got),
    .got_valid_out(gv));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out;
    failures += eq.size() + gq.size() + pq.size() + aq.size();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  task automatic drain;
    for (int i = 0; i < 8000 && eq.size() > 0; i++) @(posedge clk_in);
  endtask : drain
  task automatic pkt(input logic [7:0] l, input logic bad);
    logic [7:0] p;
    p = 8'($urandom_range(1, 255));
    eq.push_back((l == 8'h03 && !bad) ? SBPL_ACK_BYTE : SBPL_NAK_BYTE);
    gq.push_back(l == 8'h03 && !bad);
    if (l == 8'h03) pq.push_back(p);
    u_host.send(8'h00);
    u_host.send(l);
    if (l == 8'h03) begin
      u_host.send(bad ? p + 8'h01 : p);
      u_host.send(p);
    end
    drain;
  endtask : pkt
  task automatic send_pkt(input logic [7:0] ans);
    pay[0] = 8'($urandom_range(1, 255));
    pay[1] = 8'($urandom_range(1, 255));
    eq = '{8'h04, pay[0] + pay[1], pay[0], pay[1]};
    aq.push_back(ans == SBPL_ACK_BYTE);
    @(negedge clk_in) tx_start_in = 1'b1;
    tx_len_in = 8'h04;
    @(negedge clk_in) tx_start_in = 1'b0;
    drain;
    u_host.send(8'h00);
    u_host.send(ans);
    for (int i = 0; i < 2000 && aq.size() > 0; i++) @(posedge clk_in);
  endtask : send_pkt
  always @(posedge gv)
    if (got !== 8'h00 || (eq.size() > 0 && eq[0] === 8'h00))
      check(got, eq.size() > 0 ? eq.pop_front() : 8'hxx);
  always @(negedge clk_in) begin
    if (rx_done_out === 1'b1)
      check({7'h00, rx_good_out}, {7'h00, gq.size() > 0 ? gq.pop_front() : 1'bx});
    if (rx_byte_valid_out === 1'b1)
      check(rx_byte_out, pq.size() > 0 ? pq.pop_front() : 8'hxx);
    if ((tx_acked_out | tx_nacked_out) === 1'b1)
      check({7'h00, tx_acked_out}, {7'h00, aq.size() > 0 ? aq.pop_front() : 1'bx});
  end
  initial begin
    #200000;
    failures++;
    close_out;
  end
  initial begin
    void'($urandom(84));
    repeat (12) @(posedge clk_in);
    @(negedge clk_in) nrst_in = 1'b1;
    eq.push_back(SBPL_ACK_BYTE);
    u_host.send(8'h55);
    u_host.send(8'h55);
    drain;
    check({6'h00, active_port_out}, {6'h00, SBPL_PORT_ASYNC});
    for (int k = 0; k < 3; k++) pkt(k == 2 ? 8'h01 : 8'h03, k == 1);
    @(negedge clk_in) spi_cs_n_in = 1'b0;
    for (int i = 0; i < 8; i++) begin
      #40 spi_sck_in = 1'b0;
      spi_mosi_in = 1'($urandom);
      #40 spi_sck_in = 1'b1;
    end
    #40 spi_cs_n_in = 1'b1;
    repeat (20) @(posedge clk_in);
    check({6'h00, active_port_out}, {6'h00, SBPL_PORT_ASYNC});
    @(negedge clk_in) tx_start_in = 1'b1;
    tx_len_in = 8'h01;
    @(negedge clk_in) tx_start_in = 1'b0;
    send_pkt(SBPL_ACK_BYTE);
    send_pkt(SBPL_NAK_BYTE);
    send_pkt(SBPL_ACK_BYTE);
    close_out;
  end
endmodule : tb
`default_nettype wire
